// ### rtl/ibh_pkg.sv
// Purpose: constants and types for the input bus host control/status block
// Assumes: 100 MHz core clock, APB register access
// Notes:   field names coined from what each bit does
// Functional notes
// RULE_01: set the service request error bit when another device wanted service
// RULE_02: after a service request in autopoll, hunt the requester next poll
// RULE_03: timeout after 1 to 7 received bits sets data lost and data present
// RULE_04: silent known device on a software talk sets no response and data present
// RULE_05: bus reset bit drives a bus reset and clears itself when done
// RULE_06: software sets response expected for talk commands
// RULE_07: with response expected, listen and post data or raise an error
// RULE_08: software sets send to bus only after loading the command
// RULE_09: send to bus transmits the command and clears when done
// RULE_10: software sets transfer access request to ask for the file
// RULE_11: autopolling runs for as long as autopoll enable is set; code waits while data present, grant or request is set, or map is zero
// RULE_12: sixteen bit device map, low byte at 0x0F0, high at 0x100
// RULE_13: the autopoll uses the device map to choose addresses
// RULE_14: transfer grant is set when software may write the command
// RULE_15: data present is set whenever the file holds data for software
// RULE_16: clearing transfer grant samples send to bus and starts sending
// RULE_17: reserved bits read zero and ignore writes
package ibh_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [11:0] ERR_OFS   = 12'h0C0;
	localparam logic [11:0] XFER_OFS  = 12'h0D0;
	localparam logic [11:0] POLL_OFS  = 12'h0E0;
	localparam logic [11:0] MAPLO_OFS = 12'h0F0;
	localparam logic [11:0] MAPHI_OFS = 12'h100;
	localparam logic [11:0] STAT_OFS  = 12'h110;
	localparam logic [11:0] RXD_OFS   = 12'h114;
	localparam logic [11:0] CMD_OFS   = 12'h118;
	localparam logic [11:0] IRQS_OFS  = 12'h120;
	localparam logic [11:0] IRQM_OFS  = 12'h124;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int ERR_NORESP  = 0;
	localparam int ERR_LOST    = 1;
	localparam int ERR_SVCREQ  = 2;
	localparam int XFER_REQ    = 0;
	localparam int XFER_SEND   = 1;
	localparam int XFER_RESP   = 2;
	localparam int XFER_BUSRST = 3;
	localparam int ST_DATA   = 0;
	localparam int ST_GRANT  = 1;
	localparam int ST_APD    = 2;
	localparam logic [3:0] TALK_CODE = 4'hC;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_MAP  = 16'h0000;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ            = 100;
	localparam int BIT_CELL_US        = 100;
	localparam int CELL_MAX_US        = 104;
	localparam int STOP_TO_START_MAX_US = 260;
	localparam int BUS_RESET_US       = 3000;
	localparam int LOW1_PCT           = 35;
	localparam int LOW0_PCT           = 65;
	localparam int BIT_CYC  = BIT_CELL_US * CLK_MHZ;
	localparam int CELL_CYC = CELL_MAX_US * CLK_MHZ;
	localparam int STS_CYC  = STOP_TO_START_MAX_US * CLK_MHZ;
	localparam int RST_CYC  = BUS_RESET_US * CLK_MHZ;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} ibh_apb_req_t;
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_RESET  = 3'b001,
		ST_SEND   = 3'b010,
		ST_LISTEN = 3'b011,
		ST_RECV   = 3'b100
	} ibh_state_t;
endpackage : ibh_pkg

// ### rtl/ibh_ctrl.sv
// Purpose: host controller control/status for a single-wire input bus
// Assumes: linkIn synchronous to core_clk; open-drain pin resolved outside
// Notes:   zero-wait APB slave; long counts are parameters
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ibh_ctrl #(
	parameter int BIT_CYC  = ibh_pkg::BIT_CYC,
	parameter int CELL_CYC = ibh_pkg::CELL_CYC,
	parameter int STS_CYC  = ibh_pkg::STS_CYC,
	parameter int RST_CYC  = ibh_pkg::RST_CYC
) (
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  clkEn,
	// apb
	input  wire ibh_pkg::ibh_apb_req_t apbReq,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	// bus pin
	input  wire logic                  linkIn,
	output logic                       linkOut,
	output logic                       linkOe,
	// interrupt
	output logic                       irq
);
	import ibh_pkg::*;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	localparam int LOW1 = BIT_CYC * LOW1_PCT / 100;
	localparam int LOW0 = BIT_CYC * LOW0_PCT / 100;
	localparam int HALF = BIT_CYC / 2;

	function automatic logic at(input logic [11:0] a, input logic [11:0] o);
		return a == o;
	endfunction : at

	function automatic logic [3:0] nextActive(input logic [15:0] m, input logic [3:0] c);
		logic [3:0] r;
		logic [3:0] k;
		r = c;
		for (int i = 15; i >= 1; i--) begin
			k = c + 4'(i);
			if (m[k]) r = k;
		end
		return r;
	endfunction : nextActive

	ibh_state_t  state;
	logic [19:0] cnt;
	logic [3:0]  bitIdx, bitCnt, pollAddr;
	logic [7:0]  txSh, rxSh, rxData, cmdByte;
	logic [2:0]  errFlags, irqSt, irqMsk;
	logic [3:0]  ctl;
	logic [15:0] devMap;
	logic        autopoll_enable, dfb, grant, apd, gotStart, prevIn, pollActive, srqPend;

	wire [11:0] addr   = apbReq.paddr;
	wire [7:0]  wd     = apbReq.pwdata[7:0];
	wire        acc    = apbReq.psel & apbReq.penable;
	wire        wr     = acc & apbReq.pwrite;
	wire        setup  = apbReq.psel & ~apbReq.penable;
	wire        wErr   = wr & at(addr, ERR_OFS);
	wire        wCtl   = wr & at(addr, XFER_OFS);
	wire        wPoll  = wr & at(addr, POLL_OFS);
	wire        wMapLo = wr & at(addr, MAPLO_OFS);
	wire        wMapHi = wr & at(addr, MAPHI_OFS);
	wire        wStat  = wr & at(addr, STAT_OFS);
	wire        wCmd   = wr & at(addr, CMD_OFS);
	wire        wIrqS  = wr & at(addr, IRQS_OFS);
	wire        wIrqM  = wr & at(addr, IRQM_OFS);
	wire        mapped = at(addr, ERR_OFS) | at(addr, XFER_OFS) | at(addr, POLL_OFS)
		| at(addr, MAPLO_OFS) | at(addr, MAPHI_OFS) | at(addr, STAT_OFS)
		| at(addr, RXD_OFS) | at(addr, CMD_OFS) | at(addr, IRQS_OFS) | at(addr, IRQM_OFS);

	// reserved bits read zero
	wire [7:0] rdMux =                                                  // RULE_17
		at(addr, ERR_OFS)   ? {5'h00, errFlags} :
		at(addr, XFER_OFS)  ? {4'h0, ctl} :
		at(addr, POLL_OFS)  ? {7'h00, autopoll_enable} :
		at(addr, MAPLO_OFS) ? devMap[7:0] :                                 // RULE_12
		at(addr, MAPHI_OFS) ? devMap[15:8] :
		at(addr, STAT_OFS)  ? {5'h00, apd, grant, dfb} :
		at(addr, RXD_OFS)   ? rxData :
		at(addr, CMD_OFS)   ? cmdByte :
		at(addr, IRQS_OFS)  ? {5'h00, irqSt} :
		at(addr, IRQM_OFS)  ? {5'h00, irqMsk} : 8'h00;

	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;
	assign linkOut = 1'b0;

	// ------------------------------------------------------------
	// engine events
	// ------------------------------------------------------------
	wire cellEnd  = cnt == 20'(BIT_CYC - 1);
	wire fallIn   = prevIn & ~linkIn;
	wire riseIn   = ~prevIn & linkIn;
	wire rxBit    = cnt < 20'(HALF);
	wire sendDone = (state == ST_SEND) & (bitIdx == 4'h8) & cellEnd;
	wire srqEvt   = sendDone & ~linkIn;                                   // RULE_01
	wire listenTo = (state == ST_LISTEN) & (cnt == 20'(STS_CYC - 1)) & ~fallIn;
	wire recvTo   = (state == ST_RECV) & (cnt == 20'(CELL_CYC - 1)) & ~fallIn;
	wire byteDone = (state == ST_RECV) & riseIn & gotStart & (bitCnt == 4'h7);
	wire dleEvt   = recvTo & (bitCnt != 4'h0);                            // RULE_03
	wire noResp   = listenTo | (recvTo & (bitCnt == 4'h0));
	wire nreEvt   = noResp & ~pollActive & devMap[cmdByte[7:4]];          // RULE_04
	wire postEvt  = byteDone | dleEvt | (noResp & ~pollActive);           // RULE_07
	wire rstDone  = (state == ST_RESET) & (cnt == 20'(RST_CYC - 1));
	wire grantClr = wStat & wd[ST_GRANT] & grant;
	wire startRst = (state == ST_IDLE) & ctl[XFER_BUSRST];
	wire startSnd = (state == ST_IDLE) & ~ctl[XFER_BUSRST] & grantClr & ctl[XFER_SEND]; // RULE_16
	wire startPol = (state == ST_IDLE) & ~ctl[XFER_BUSRST] & ~grantClr & autopoll_enable & ~dfb
		& ~grant & ~ctl[XFER_REQ] & (|devMap);                                // RULE_11
	wire grantSet = (state == ST_IDLE) & ctl[XFER_REQ] & ~grant & ~dfb
		& ~ctl[XFER_BUSRST];                                                  // RULE_14
	// hunt on from the last address after a service request
	wire [3:0] nextAddr = (srqPend | ~devMap[pollAddr]) ?
		nextActive(devMap, pollAddr) : pollAddr;                             // RULE_02 RULE_13
	wire [7:0] lostByte = rxSh << (4'h8 - bitCnt);
	wire       lowOne   = (bitIdx != 4'h8) & txSh[7];
	wire       drive    = (state == ST_RESET)
		| ((state == ST_SEND) & (cnt < (lowOne ? 20'(LOW1) : 20'(LOW0))));

	// ------------------------------------------------------------
	// bus engine
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			cnt <= 20'h0_0000;
			bitIdx <= 4'h0;
			bitCnt <= 4'h0;
			txSh <= RST_BYTE;
			rxSh <= RST_BYTE;
			gotStart <= 1'b0;
			prevIn <= 1'b1;
			pollActive <= 1'b0;
			srqPend <= 1'b0;
			pollAddr <= 4'h0;
			linkOe <= 1'b0;
		end else if (clkEn) begin
			prevIn <= linkIn;
			linkOe <= drive;                                          // RULE_05
			if (srqEvt & pollActive) srqPend <= 1'b1;
			else if (byteDone & pollActive) srqPend <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					cnt <= 20'h0_0000;
					bitIdx <= 4'h0;
					if (startRst) state <= ST_RESET;               // RULE_05
					else if (startSnd) begin                       // RULE_09
						state <= ST_SEND;
						txSh <= cmdByte;
						pollActive <= 1'b0;
					end else if (startPol) begin                   // RULE_11
						state <= ST_SEND;
						txSh <= {nextAddr, TALK_CODE};
						pollAddr <= nextAddr;
						pollActive <= 1'b1;
					end
				end
				ST_RESET: begin
					cnt <= cnt + 20'h0_0001;
					if (rstDone) state <= ST_IDLE;
				end
				ST_SEND: begin
					cnt <= cellEnd ? 20'h0_0000 : cnt + 20'h0_0001;
					if (cellEnd) begin
						bitIdx <= bitIdx + 4'h1;
						txSh <= {txSh[6:0], 1'b0};
					end
					if (sendDone) state <= (pollActive | ctl[XFER_RESP]) ? ST_LISTEN : ST_IDLE; // RULE_07
				end
				ST_LISTEN: begin
					cnt <= cnt + 20'h0_0001;
					if (fallIn) begin
						state <= ST_RECV;
						cnt <= 20'h0_0000;
						bitCnt <= 4'h0;
						gotStart <= 1'b0;
					end else if (listenTo) state <= ST_IDLE;
				end
				ST_RECV: begin
					cnt <= fallIn ? 20'h0_0000 : cnt + 20'h0_0001;
					if (riseIn) begin
						gotStart <= 1'b1;
						if (gotStart) begin
							rxSh <= {rxSh[6:0], rxBit};
							bitCnt <= bitCnt + 4'h1;
						end
					end
					if (byteDone | recvTo) state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	wire [2:0] next_err = (wErr ? wd[2:0] : errFlags) | {srqEvt, dleEvt, nreEvt}; // RULE_01
	wire [3:0] ctlW     = wCtl ? wd[3:0] : ctl;
	wire [3:0] next_ctl = ctlW & ~{rstDone, 1'b0, sendDone & ~pollActive, 1'b0}; // RULE_05 RULE_09
	wire [2:0] next_irq = (irqSt & ~({3{wIrqS}} & wd[2:0])) | {rstDone, grantSet, postEvt};

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			errFlags <= 3'h0;
			ctl <= 4'h0;
			autopoll_enable <= 1'b0;
			devMap <= RST_MAP;
			dfb <= 1'b0;
			grant <= 1'b0;
			apd <= 1'b0;
			rxData <= RST_BYTE;
			cmdByte <= RST_BYTE;
			irqSt <= 3'h0;
			irqMsk <= 3'h0;
			irq <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (clkEn) begin
			errFlags <= next_err;
			ctl <= next_ctl;
			if (wPoll) autopoll_enable <= wd[0];                                  // RULE_11
			if (wMapLo) devMap[7:0] <= wd;                            // RULE_12
			if (wMapHi) devMap[15:8] <= wd;
			dfb <= (dfb & ~(wStat & wd[ST_DATA])) | postEvt;          // RULE_15
			grant <= (grant & ~grantClr) | grantSet;                  // RULE_14
			apd <= ((apd & ~(wStat & wd[ST_APD])) & ~startPol) | (postEvt & pollActive);
			if (postEvt) rxData <= byteDone ? {rxSh[6:0], rxBit} : (dleEvt ? lostByte : 8'h00);
			if (postEvt & pollActive) cmdByte <= {pollAddr, TALK_CODE};
			else if (wCmd) cmdByte <= wd;
			irqSt <= next_irq;
			if (wIrqM) irqMsk <= wd[2:0];
			irq <= |(next_irq & irqMsk);
			if (setup) prdata <= {24'h00_0000, rdMux};
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst || !clkEn);

	sequence sStopSrq;
		sendDone && !linkIn;
	endsequence
	sequence sResetStart;
		startRst ##1 (state == ST_RESET);
	endsequence

	a_srq_flag_set: assert property (sStopSrq |=> errFlags[ERR_SVCREQ]) // RULE_01
		else $error("service request bit not set");
	a_poll_hunt: assert property (startPol && srqPend && nextAddr != pollAddr // RULE_02
		|=> pollAddr != $past(pollAddr)) else $error("autopoll did not hunt");
	a_data_lost: assert property (dleEvt |=> errFlags[ERR_LOST] && dfb) // RULE_03
		else $error("data lost not flagged");
	a_no_response: assert property (nreEvt |=> errFlags[ERR_NORESP] && dfb) // RULE_04
		else $error("no response not flagged");
	a_reset_drive: assert property (sResetStart |=> linkOe && ctl[XFER_BUSRST]) // RULE_05
		else $error("bus reset not driven");
	a_reset_clear: assert property (rstDone |=> !ctl[XFER_BUSRST] && state == ST_IDLE) // RULE_05
		else $error("reset bit not cleared");
	a_listen_reply: assert property (state == ST_LISTEN && fallIn |=> state == ST_RECV) // RULE_07
		else $error("reply start missed");
	a_send_clear: assert property (sendDone && !pollActive |=> !ctl[XFER_SEND]) // RULE_09
		else $error("send bit not cleared");
	a_poll_enable: assert property (state == ST_SEND && pollActive && bitIdx == 4'h0 // RULE_11
		&& cnt == 20'h0_0000 |-> $past(autopoll_enable)) else $error("poll without enable");
	a_grant_set: assert property (grantSet |=> grant ##1 grant || $past(grantClr)) // RULE_14
		else $error("grant not set");
	a_grant_send: assert property (startSnd |=> state == ST_SEND && !grant) // RULE_16
		else $error("send not started on grant clear");
endmodule : ibh_ctrl
`default_nettype wire

// ### testbench/ibh_dev_model.sv
// Purpose: behavioural bus device answering the host on the single wire
// Assumes: pull-up wire, released line reads high; core_clk timing
// Notes:   decodes the last host command, replies or asserts service request
`timescale 1ns/10ps
`default_nettype none
module ibh_dev_model #(
	parameter int BIT_CYC = 40
) (
	// clock and wire
	input  wire logic       core_clk,
	input  wire logic       hostPull,
	output logic            devPull,
	output logic [7:0]      lastCmd,
	// scenario controls
	input  wire logic       replyEn,
	input  wire logic       srqEn,
	input  wire logic [3:0] replyBits,
	input  wire logic [7:0] replyByte
);
	int lowCnt = 0;
	int pulses;
	// ------------------------------------------------------------
	// one bit cell, short low for 1
	// ------------------------------------------------------------
	task automatic drive_cell(input logic b);
		int lowLen;
		lowLen = b ? BIT_CYC * 35 / 100 : BIT_CYC * 65 / 100;
		devPull <= 1'b1;
		repeat (lowLen) @(posedge core_clk);
		devPull <= 1'b0;
		repeat (BIT_CYC - lowLen) @(posedge core_clk);
	endtask : drive_cell
	initial begin
		devPull = 1'b0;
		lastCmd = 8'h00;
		forever begin
			pulses = 0;
			while (pulses < 9) begin
				@(posedge core_clk);
				if (hostPull === 1'b1) lowCnt++;
				else if (lowCnt > 0) begin
					// a long pulse is a bus reset, restart framing
					if (lowCnt > BIT_CYC) pulses = 0;
					else begin
						if (pulses < 8) lastCmd = {lastCmd[6:0], lowCnt < BIT_CYC / 2};
						pulses++;
					end
					lowCnt = 0;
				end
			end
			if (srqEn) begin
				devPull <= 1'b1;
				repeat (20) @(posedge core_clk);
				devPull <= 1'b0;
			end else if (replyEn) begin
				repeat (BIT_CYC) @(posedge core_clk);
				drive_cell(1'b1);
				for (int i = 0; i < replyBits; i++) drive_cell(replyByte[7 - i]);
			end
		end
	end
endmodule : ibh_dev_model
`default_nettype wire

// ### testbench/ibh_tb.sv
// Purpose: self-checking bench for the input bus host control block
// Assumes: APB master with one idle cycle between transfers
// Notes:   short timing parameters keep the run small
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import ibh_pkg::*;
	localparam int RST_N = 50;
	logic              core_clk;
	logic              sys_rst;
	ibh_apb_req_t      apbReq;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              linkOe;
	logic              irq;
	logic              devPull;
	logic [7:0]        lastCmd;
	logic              replyEn;
	logic              srqEn;
	logic [3:0]        replyBits;
	logic [7:0]        replyByte;
	logic              wireLvl;
	int                err_total = 0;
	int                checked = 0;
	assign wireLvl = ~(linkOe | devPull);
	ibh_ctrl #(.BIT_CYC(40), .CELL_CYC(44), .STS_CYC(120), .RST_CYC(RST_N)) uut (
		.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(1'b1), .apbReq(apbReq),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .linkIn(wireLvl),
		.linkOut(), .linkOe(linkOe), .irq(irq));
	ibh_dev_model #(.BIT_CYC(40)) dev (
		.core_clk(core_clk), .hostPull(linkOe), .devPull(devPull), .lastCmd(lastCmd),
		.replyEn(replyEn), .srqEn(srqEn), .replyBits(replyBits), .replyByte(replyByte));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic finish_test;
		if (err_total == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
			output logic [31:0] rd, output logic err);
		int n;
		@(posedge core_clk);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {24'h0000_00, d}};
		@(posedge core_clk);
		apbReq.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			chk(32'h0000_0000, 32'h0000_0001);
			finish_test();
		end
		rd = prdata;
		err = pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] rd;
		logic        e;
		apb(1'b1, a, d, rd, e);
	endtask : wr
	task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
		logic [31:0] rd;
		logic        e;
		apb(1'b0, a, 8'h00, rd, e);
		chk(rd, {24'h0000_00, exp});
	endtask : rdchk
	task automatic poll(input logic [11:0] a, input int idx, input logic val);
		logic [31:0] rd;
		logic        e;
		int          n;
		n = 0;
		do begin
			apb(1'b0, a, 8'h00, rd, e);
			n++;
		end while (rd[idx] !== val && n < 1000);
		if (n >= 1000) begin
			chk(rd, {31'h0000_0000, val});
			finish_test();
		end
	endtask : poll
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		logic [31:0] rd;
		logic        e;
		rdchk(ERR_OFS, 8'h00);
		rdchk(XFER_OFS, 8'h00);
		rdchk(POLL_OFS, 8'h00);
		rdchk(MAPLO_OFS, 8'h00);
		rdchk(MAPHI_OFS, 8'h00);
		wr(ERR_OFS, 8'hFF);
		rdchk(ERR_OFS, 8'h07);
		wr(XFER_OFS, 8'hF0);
		rdchk(XFER_OFS, 8'h00);
		wr(POLL_OFS, 8'hFE);
		rdchk(POLL_OFS, 8'h00);
		wr(MAPLO_OFS, 8'hA5);
		wr(MAPHI_OFS, 8'h3C);
		rdchk(MAPLO_OFS, 8'hA5);
		rdchk(MAPHI_OFS, 8'h3C);
		apb(1'b0, 12'h0C4, 8'h00, rd, e);
		chk(rd, 32'h0000_0000);
		chk({31'h0000_0000, e}, 32'h0000_0001);
		wr(ERR_OFS, 8'h00);
	endtask : t_regs
	task automatic t_bus_reset;
		int n;
		wr(IRQM_OFS, 8'h04);
		wr(XFER_OFS, 8'h08);
		n = 0;
		while (linkOe !== 1'b1 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		n = 0;
		while (linkOe === 1'b1 && n < 1000) begin
			@(negedge core_clk);
			n++;
		end
		chk(n, RST_N);
		poll(XFER_OFS, XFER_BUSRST, 1'b0);
		rdchk(IRQS_OFS, 8'h04);
		chk(irq, 1'b1);
		wr(IRQM_OFS, 8'h00);
		repeat (2) @(posedge core_clk);
		chk(irq, 1'b0);
		wr(IRQM_OFS, 8'h04);
		wr(IRQS_OFS, 8'h04);
		repeat (2) @(posedge core_clk);
		chk(irq, 1'b0);
		wr(IRQM_OFS, 8'h00);
	endtask : t_bus_reset
	task automatic t_talk(input logic [7:0] cmd, input logic en, input logic service_request,
			input logic [3:0] nb, input logic [7:0] rb, input logic [7:0] expRx,
			input logic [7:0] expErr);
		replyEn <= en;
		srqEn <= service_request;
		replyBits <= nb;
		replyByte <= rb;
		wr(XFER_OFS, 8'h01);
		poll(STAT_OFS, ST_GRANT, 1'b1);
		wr(CMD_OFS, cmd);
		wr(XFER_OFS, 8'h06);
		wr(STAT_OFS, 8'h02);
		poll(XFER_OFS, XFER_SEND, 1'b0);
		chk(lastCmd, cmd);
		poll(STAT_OFS, ST_DATA, 1'b1);
		if (en && nb != 4'h0) rdchk(RXD_OFS, expRx);
		rdchk(ERR_OFS, expErr);
		wr(ERR_OFS, 8'h00);
		wr(STAT_OFS, 8'h07);
		wr(XFER_OFS, 8'h00);
		wr(IRQS_OFS, 8'h07);
	endtask : t_talk
	task automatic t_autopoll;
		wr(MAPLO_OFS, 8'h08);
		wr(MAPHI_OFS, 8'h00);
		replyEn <= 1'b1;
		srqEn <= 1'b0;
		replyBits <= 4'h8;
		replyByte <= 8'h5A;
		wr(POLL_OFS, 8'h01);
		poll(STAT_OFS, ST_DATA, 1'b1);
		wr(POLL_OFS, 8'h00);
		rdchk(STAT_OFS, 8'h05);
		rdchk(CMD_OFS, 8'h3C);
		chk(lastCmd, 8'h3C);
		rdchk(RXD_OFS, 8'h5A);
		wr(STAT_OFS, 8'h07);
	endtask : t_autopoll
	// ------------------------------------------------------------
	// clock and main sequence
	// ------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		sys_rst = 1'b1;
		apbReq = '0;
		{replyEn, srqEn, replyBits, replyByte} = '0;
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_regs();
		t_bus_reset();
		t_talk(8'h2C, 1'b1, 1'b0, 4'h8, 8'hA5, 8'hA5, 8'h00);
		t_talk(8'h2C, 1'b1, 1'b0, 4'h3, 8'hBF, 8'hA0, 8'h02);
		t_talk(8'h2C, 1'b0, 1'b0, 4'h0, 8'h00, 8'h00, 8'h01);
		t_talk(8'h5C, 1'b0, 1'b1, 4'h0, 8'h00, 8'h00, 8'h05);
		t_autopoll();
		finish_test();
	end
endmodule : testbench
`default_nettype wire
